// ===== verilog/pci_interlock.v
// What this block does
// - zero muting time disables startup muting
// - ignore intervention while startup high, top low
// - no plausibility check; repeated startups mute again
// - muting timer starts on startup rising edge
// - muting ends on timeout/startup low; drop release if interrupted
// - new startup rise while released restarts muting
// - cycle time overrun flags and needs complete sequence
// - top position rise starts cycle timer
// - other starts: first pulse or start end
// - cycle limit defaults 30 s; zero disables
// - second release: none, always, first start
// - first-cycle setting picks valid intervention start
// - intervention end must follow top rise
// - interlock setting 1 needs no restart sequence
// - complete sequence order follows standard/Sweden mode
// - setting 2 unmuted: intervention latches interlock
// - setting 2 muted: intervention, startup low latches
// - setting 2, first 2: muted intervention may count
// - muted intervention ended early latches at top
// - setting 2, first 1: muted intervention latches at top
// - setting 3: downstroke or top intervention latches
// - setting 3 muting expiry drop, restore on end
// - setting 3 tolerates one pulse after expiry
// - muting time 0 or 1 to 7200 s
// - cycle limit 0 or 1 to 500 s
// - short interventions below minimum are ignored
// - start pulse between minimum and 30 s
//
// The implementer's own choices: the address map and the plain strobed port.
`include "pci_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module pci_interlock #(
   parameter TICK_CYC = `PCI_TICK_CYC
) (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Register port
   input wire [3:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdata,
   // Press and guard inputs
   input wire lightCurtainSwitchOutput,
   input wire strokeTopPosition,
   input wire startupIn,
   input wire startIn,
   input wire release1In,
   input wire release2In,
   // Status outputs
   output wire releaseOut,
   output wire fieldIntervOut,
   output wire cycleRequiredOut,
   output wire startRequiredOut,
   output wire cycleTimeExceededOut,
   output wire mutingOut
);
   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   wire [5:0] lvl;
   wire [5:0] rise;
   wire [5:0] fall;
   pci_sync #(.W(6)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .async({release2In, release1In, startIn, startupIn,
              strokeTopPosition, lightCurtainSwitchOutput}),
      .lvl(lvl),
      .rise(rise),
      .fall(fall)
   );
   wire cyc = lvl[0];
   wire top = lvl[1];
   wire su = lvl[2];
   wire rel1 = lvl[4];
   wire rel2 = lvl[5];
   wire cycFall = fall[0];
   wire cycRise = rise[0];
   wire topRise = rise[1];
   wire suRise = rise[2];
   wire stRise = rise[3];
   wire stFall = fall[3];
   // ---------------------------------------------------------------
   // Millisecond tick
   // ---------------------------------------------------------------
   localparam integer TICK_LAST_I = TICK_CYC - 1;
   localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];
   reg [15:0] tickCnt_r;
   wire tick = (tickCnt_r == TICK_LAST);
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tickCnt_r <= 16'h0000;
      end else if (tick) begin
         tickCnt_r <= 16'h0000;
      end else begin
         tickCnt_r <= tickCnt_r + 16'h0001;
      end
   end
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [`PCI_CFG_W-1:0] cfg_r;
   reg [12:0] muteSec_r;
   reg [8:0] cycSec_r;
   wire [3:0] nCyc = cfg_r[`PCI_CFG_NCYC];
   wire sweden = cfg_r[`PCI_CFG_SWEDEN];
   wire [1:0] rel2Set = cfg_r[`PCI_CFG_REL2];
   wire first2 = (cfg_r[`PCI_CFG_FIRST] == `PCI_SET2);
   wire ril1 = (cfg_r[`PCI_CFG_RIL] == `PCI_SET1);
   wire ril3 = (cfg_r[`PCI_CFG_RIL] == `PCI_SET3);
   wire ril2 = !ril1 && !ril3;
   wire [14:0] minCyc = cfg_r[`PCI_CFG_MINCYC] ? `PCI_PULSE_LONG_MS : `PCI_PULSE_SHORT_MS;
   wire [14:0] minSt = cfg_r[`PCI_CFG_MINST] ? `PCI_PULSE_LONG_MS : `PCI_PULSE_SHORT_MS;
   wire muteEn = (muteSec_r != 13'h0000);
   wire ctEn = (cycSec_r != 9'h000);
   wire [`PCI_MS_W-1:0] muteLim = {10'h000, muteSec_r} * `PCI_MS_PER_S;
   wire [`PCI_MS_W-1:0] ctLim = {14'h0000, cycSec_r} * `PCI_MS_PER_S;
   reg [31:0] stat;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_r <= `PCI_CFG_RST;
         muteSec_r <= `PCI_MUTE_RST;
         cycSec_r <= `PCI_CYCT_DEF_S;
      end else if (regWr) begin
         case (regAddr)
            `PCI_REG_CFG: begin
               cfg_r <= regWdata[`PCI_CFG_W-1:0];
            end
            `PCI_REG_MUTE: begin
               if (regWdata > {19'h00000, `PCI_MUTE_MAX_S}) begin
                  muteSec_r <= `PCI_MUTE_MAX_S;
               end else begin
                  muteSec_r <= regWdata[12:0];
               end
            end
            `PCI_REG_CYCT: begin
               if (regWdata > {23'h000000, `PCI_CYCT_MAX_S}) begin
                  cycSec_r <= `PCI_CYCT_MAX_S;
               end else begin
                  cycSec_r <= regWdata[8:0];
               end
            end
            default: begin
            end
         endcase
      end
   end
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 32'h00000000;
      end else if (regRd) begin
         case (regAddr)
            `PCI_REG_CFG: regRdata <= {19'h00000, cfg_r};
            `PCI_REG_MUTE: regRdata <= {19'h00000, muteSec_r};
            `PCI_REG_CYCT: regRdata <= {23'h000000, cycSec_r};
            `PCI_REG_STAT: regRdata <= stat;
            default: regRdata <= 32'h00000000;
         endcase
      end else begin
         regRdata <= 32'h00000000;
      end
   end
   // ---------------------------------------------------------------
   // Pulse length qualification
   // ---------------------------------------------------------------
   reg [14:0] cycLowMs_r;
   reg [14:0] stHighMs_r;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cycLowMs_r <= 15'h0000;
         stHighMs_r <= 15'h0000;
      end else begin
         if (cycFall) begin
            cycLowMs_r <= 15'h0000;
         end else if (tick && !cyc && cycLowMs_r != 15'h7FFF) begin
            cycLowMs_r <= cycLowMs_r + 15'h0001;
         end
         if (stRise) begin
            stHighMs_r <= 15'h0000;
         end else if (tick && lvl[3] && stHighMs_r != 15'h7FFF) begin
            stHighMs_r <= stHighMs_r + 15'h0001;
         end
      end
   end
   wire pulseOk = cycRise && (cycLowMs_r >= minCyc);
   wire startOk = stFall && (stHighMs_r >= minSt)
                  && (stHighMs_r <= `PCI_START_MAX_MS);
   // ---------------------------------------------------------------
   // Sequence state
   // ---------------------------------------------------------------
   reg run_r;
   reg fieldInterv_r;
   reg interlock_r;
   reg cycReq_r;
   reg startDone_r;
   reg [3:0] cnt_r;
   reg muting_r;
   reg [`PCI_MS_W-1:0] muteMs_r;
   reg afterTop_r;
   reg afterSu_r;
   reg fellOk_r;
   reg mutedHit_r;
   reg mutedEnded_r;
   reg softStop_r;
   reg tol_r;
   reg ctRun_r;
   reg [`PCI_MS_W-1:0] ctMs_r;
   reg ctExc_r;
   wire cntDone = (cnt_r >= nCyc);
   wire rel2Ok = (rel2Set == `PCI_SET2) ? rel2 :
                 (rel2Set == `PCI_SET3) ? (rel2 || !interlock_r) : 1'b1;
   wire muteTimeUp = (muteMs_r >= muteLim);
   wire muteStop = muting_r && (!su || muteTimeUp || top);
   wire muteDrop = muting_r && !cyc && (!su || muteTimeUp) && !top;
   wire muteExpOk = muting_r && cyc && (!su || muteTimeUp) && !top;
   wire cntGate = !run_r && (!interlock_r || !sweden || startDone_r || ril1);
   wire validCnt = pulseOk && fellOk_r && afterTop_r && cntGate;
   wire seqDone = interlock_r ? (cntDone && (startDone_r || ril1))
                              : (cycReq_r && cntDone);
   wire grant = !run_r && !softStop_r && seqDone && rel2Ok && rel1;
   wire intrude = run_r && cycFall && !muting_r;
   wire ctOver = ctRun_r && ctEn && (ctMs_r >= ctLim);
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         run_r <= 1'b0;
         fieldInterv_r <= 1'b0;
         interlock_r <= 1'b1;
         cycReq_r <= 1'b0;
         startDone_r <= 1'b0;
         cnt_r <= 4'h0;
         muting_r <= 1'b0;
         muteMs_r <= {`PCI_MS_W{1'b0}};
         afterTop_r <= 1'b0;
         afterSu_r <= 1'b0;
         fellOk_r <= 1'b0;
         mutedHit_r <= 1'b0;
         mutedEnded_r <= 1'b0;
         softStop_r <= 1'b0;
         tol_r <= 1'b0;
         ctRun_r <= 1'b0;
         ctMs_r <= {`PCI_MS_W{1'b0}};
         ctExc_r <= 1'b0;
      end else begin
         // Startup muting window.
         if (muteEn && suRise && !top && (!muting_r || run_r)) begin
            muting_r <= 1'b1;
            muteMs_r <= {`PCI_MS_W{1'b0}};
         end else if (muteStop || !muteEn) begin
            muting_r <= 1'b0;
         end else if (tick && muting_r) begin
            muteMs_r <= muteMs_r + 1'b1;
         end
         if (suRise) begin
            afterSu_r <= 1'b1;
         end
         // Intervention start qualification.
         if (cycFall) begin
            fellOk_r <= first2 ? (afterSu_r || suRise || afterTop_r) : afterTop_r;
            if (muting_r) begin
               mutedHit_r <= 1'b1;
               mutedEnded_r <= 1'b0;
            end
         end
         if (cycRise && mutedHit_r && !afterTop_r) begin
            mutedEnded_r <= 1'b1;
         end
         if (validCnt && cnt_r != 4'hF) begin
            cnt_r <= cnt_r + 4'h1;
         end
         if (startOk && interlock_r && !run_r && (sweden || cntDone)) begin
            startDone_r <= 1'b1;
         end
         // Cycle time supervision.
         if (ctRun_r && tick) begin
            ctMs_r <= ctMs_r + 1'b1;
         end
         if (!ctRun_r && !run_r && interlock_r &&
             ((!sweden && validCnt && cnt_r == 4'h0) || (sweden && startOk))) begin
            ctRun_r <= 1'b1;
            ctMs_r <= {`PCI_MS_W{1'b0}};
         end
         // Stops while the press runs.
         if (intrude) begin
            if (ril3 && su && !top && tol_r) begin
               softStop_r <= 1'b1;
               tol_r <= 1'b0;
               run_r <= 1'b0;
               fieldInterv_r <= 1'b1;
            end else if (ril1) begin
               run_r <= 1'b0;
               fieldInterv_r <= 1'b1;
               cycReq_r <= 1'b1;
               cnt_r <= 4'h0;
            end else begin
               run_r <= 1'b0;
               fieldInterv_r <= 1'b1;
               interlock_r <= 1'b1;
               cnt_r <= 4'h0;
               startDone_r <= 1'b0;
            end
         end
         if (muteDrop && run_r) begin
            run_r <= 1'b0;
            fieldInterv_r <= 1'b1;
            if (ril2) begin
               interlock_r <= 1'b1;
               cnt_r <= 4'h0;
               startDone_r <= 1'b0;
            end else begin
               softStop_r <= 1'b1;
            end
         end
         if (muteExpOk && ril3) begin
            tol_r <= 1'b1;
         end
         if (softStop_r && cycRise) begin
            softStop_r <= 1'b0;
            run_r <= 1'b1;
            fieldInterv_r <= 1'b0;
         end
         // Top position reached.
         if (topRise) begin
            afterTop_r <= 1'b1;
            afterSu_r <= 1'b0;
            mutedHit_r <= 1'b0;
            softStop_r <= 1'b0;
            tol_r <= 1'b0;
            run_r <= 1'b0;
            cnt_r <= 4'h0;
            ctRun_r <= 1'b1;
            ctMs_r <= {`PCI_MS_W{1'b0}};
            if (ril2 && mutedHit_r && (!first2 || mutedEnded_r)) begin
               interlock_r <= 1'b1;
               fieldInterv_r <= 1'b1;
               startDone_r <= 1'b0;
            end else if (!interlock_r) begin
               cycReq_r <= 1'b1;
            end
         end
         // Overrun wins over any grant in the same cycle.
         if (ctOver) begin
            ctExc_r <= 1'b1;
            ctRun_r <= 1'b0;
            interlock_r <= 1'b1;
            run_r <= 1'b0;
            cnt_r <= 4'h0;
            startDone_r <= 1'b0;
         end else if (grant && !topRise && !intrude) begin
            run_r <= 1'b1;
            fieldInterv_r <= 1'b0;
            interlock_r <= 1'b0;
            cycReq_r <= 1'b0;
            startDone_r <= 1'b0;
            cnt_r <= 4'h0;
            ctRun_r <= 1'b0;
            ctExc_r <= 1'b0;
            afterTop_r <= 1'b0;
            fellOk_r <= 1'b0;
            mutedEnded_r <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   wire cycReqNxt = !run_r && (interlock_r ?
                    ((sweden ? (startDone_r || ril1) : 1'b1) && !cntDone) :
                    (cycReq_r && !cntDone));
   wire stReqNxt = !run_r && interlock_r && !ril1 && !startDone_r
                   && (sweden || cntDone);
   reg release_r;
   reg cycReqOut_r;
   reg stReqOut_r;
   reg fieldOut_r;
   reg ctExcOut_r;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         release_r <= 1'b0;
         cycReqOut_r <= 1'b0;
         stReqOut_r <= 1'b0;
         fieldOut_r <= 1'b0;
         ctExcOut_r <= 1'b0;
      end else begin
         release_r <= run_r && rel1;
         cycReqOut_r <= cycReqNxt;
         stReqOut_r <= stReqNxt;
         fieldOut_r <= fieldInterv_r;
         ctExcOut_r <= ctExc_r;
      end
   end
   always @* begin
      stat = {20'h00000, cnt_r, ctExc_r, interlock_r, muting_r, stReqOut_r,
              cycReqOut_r, fieldInterv_r, softStop_r, release_r};
   end
   assign releaseOut = release_r;
   assign fieldIntervOut = fieldOut_r;
   assign cycleRequiredOut = cycReqOut_r;
   assign startRequiredOut = stReqOut_r;
   assign cycleTimeExceededOut = ctExcOut_r;
   assign mutingOut = muting_r;
endmodule
`default_nettype wire

// ===== verilog/pci_defines.vh
`ifndef PCI_DEFINES_VH
`define PCI_DEFINES_VH
// ---------------------------------------------------------------
// Clock and tick timing
// ---------------------------------------------------------------
`define PCI_CLK_HZ 50000000
`define PCI_TICK_US 1000
`define PCI_TICK_CYC ((`PCI_CLK_HZ / 1000000) * `PCI_TICK_US)
`define PCI_MS_PER_S 23'h0003E8
`define PCI_MS_W 23
// ---------------------------------------------------------------
// Limits in their own units
// ---------------------------------------------------------------
`define PCI_MUTE_MAX_S 13'h1C20
`define PCI_CYCT_MAX_S 9'h1F4
`define PCI_CYCT_DEF_S 9'h01E
`define PCI_PULSE_SHORT_MS 15'h0064
`define PCI_PULSE_LONG_MS 15'h015E
`define PCI_START_MAX_S 30
`define PCI_START_MAX_MS 15'h7530
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define PCI_REG_CFG 4'h0
`define PCI_REG_MUTE 4'h4
`define PCI_REG_CYCT 4'h8
`define PCI_REG_STAT 4'hC
// ---------------------------------------------------------------
// Configuration fields and reset values
// ---------------------------------------------------------------
`define PCI_CFG_NCYC 3:0
`define PCI_CFG_SWEDEN 4
`define PCI_CFG_REL2 6:5
`define PCI_CFG_FIRST 8:7
`define PCI_CFG_RIL 10:9
`define PCI_CFG_MINCYC 11
`define PCI_CFG_MINST 12
`define PCI_CFG_W 13
`define PCI_CFG_RST 13'h0481
`define PCI_MUTE_RST 13'h0000
`define PCI_SET1 2'h1
`define PCI_SET2 2'h2
`define PCI_SET3 2'h3
`endif

// ===== verilog/pci_sync.v
`timescale 1ns/1ps
`default_nettype none
module pci_sync #(
   parameter W = 6
) (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Asynchronous levels
   input wire [W-1:0] async,
   // Synchronised levels and edges
   output wire [W-1:0] lvl,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg s1_r;
         reg s2_r;
         reg s3_r;
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
            end else begin
               s1_r <= async[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
            end
         end
         assign lvl[i] = s2_r;
         assign rise[i] = s2_r & ~s3_r;
         assign fall[i] = ~s2_r & s3_r;
      end
   endgenerate
endmodule
`default_nettype wire

// ===== verification/pci_press_model.sv
`timescale 1ns/1ps
`default_nettype none
module pci_press_model #(
   parameter int TICK = 10
) (
   // Clock
   input wire logic clk,
   // Guard, press contacts and operator button
   output logic curtain,
   output logic top,
   output logic startup,
   output logic start
);
   // ---------------------------------------------------------------
   // Line drivers
   // ---------------------------------------------------------------
   initial begin
      curtain = 1'b1;
      top = 1'b0;
      startup = 1'b0;
      start = 1'b0;
   end

   task automatic drive(input int line, input logic v);
      @(posedge clk);
      case (line)
         0: curtain <= v;
         1: top <= v;
         2: startup <= v;
         default: start <= v;
      endcase
   endtask

   // A pulse holds the line at v for whole milliseconds, then returns it.
   task automatic pulse(input int line, input logic v, input int ms);
      drive(line, v);
      repeat (ms * TICK) @(posedge clk);
      drive(line, !v);
   endtask
endmodule
`default_nettype wire

// ===== verification/pci_interlock_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "pci_defines.vh"
module pci_interlock_properties #(
   parameter TICK_CYC = 50000
) (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Register port
   input wire [3:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   input wire [31:0] regRdata,
   // Press inputs
   input wire startupIn,
   input wire release1In,
   // Status outputs
   input wire releaseOut,
   input wire fieldIntervOut,
   input wire cycleRequiredOut,
   input wire startRequiredOut,
   input wire cycleTimeExceededOut,
   input wire mutingOut
);
   // ---------------------------------------------------------------
   // Shadow of the zero settings
   // ---------------------------------------------------------------
   logic muteOff_r;
   logic cyctOff_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         muteOff_r <= 1'b1;
         cyctOff_r <= 1'b0;
      end else if (regWr && regAddr == `PCI_REG_MUTE) begin
         muteOff_r <= (regWdata == 32'h0);
      end else if (regWr && regAddr == `PCI_REG_CYCT) begin
         cyctOff_r <= (regWdata == 32'h0);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data not idle");
   release_gate_a: assert property ((!release1In) [*6] |-> !releaseOut)
      else $error("release high while main release low");
   grant_clean_a: assert property (releaseOut |-> !cycleRequiredOut && !startRequiredOut)
      else $error("release high with a request pending");
   seq_exclusive_a: assert property (!(cycleRequiredOut && startRequiredOut))
      else $error("both sequence parts requested");
   field_release_a: assert property (fieldIntervOut |-> !releaseOut)
      else $error("release high during field intervention");
   overrun_hold_a: assert property (cycleTimeExceededOut |-> !releaseOut)
      else $error("release high after overrun");
   mute_off_a: assert property (muteOff_r [*3] |-> !mutingOut)
      else $error("muting with zero time");
   cyct_off_a: assert property (cyctOff_r [*3] |-> !$rose(cycleTimeExceededOut))
      else $error("overrun with supervision off");
   mute_start_a: assert property ($rose(mutingOut) |-> $past(startupIn, 2))
      else $error("muting without startup");
   mute_end_a: assert property ((!startupIn) [*6] |-> !mutingOut)
      else $error("muting after startup low");
endmodule

bind pci_interlock pci_interlock_properties #(.TICK_CYC(TICK_CYC)) props_i (
   .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .regRd(regRd), .regRdata(regRdata), .startupIn(startupIn), .release1In(release1In),
   .releaseOut(releaseOut), .fieldIntervOut(fieldIntervOut),
   .cycleRequiredOut(cycleRequiredOut), .startRequiredOut(startRequiredOut),
   .cycleTimeExceededOut(cycleTimeExceededOut), .mutingOut(mutingOut));
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pci_defines.vh"
module testbench;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   localparam int TICK = 10;
   localparam int CURT = 0;
   localparam int TOP = 1;
   localparam int STUP = 2;
   localparam int STRT = 3;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic release1In = 1'b1;
   logic release2In = 1'b1;
   wire logic [31:0] regRdata;
   wire logic curtain, top, startup, start, releaseOut, fieldIntervOut;
   wire logic cycleRequiredOut, startRequiredOut, cycleTimeExceededOut, mutingOut;
   int mismatches = 0;
   int numChecks = 0;
   logic [31:0] rd;

   always #10 clk = ~clk;

   pci_interlock #(.TICK_CYC(TICK)) pci_interlock_i (.clk(clk), .rstn(rstn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .lightCurtainSwitchOutput(curtain), .strokeTopPosition(top),
      .startupIn(startup), .startIn(start), .release1In(release1In),
      .release2In(release2In), .releaseOut(releaseOut), .fieldIntervOut(fieldIntervOut),
      .cycleRequiredOut(cycleRequiredOut), .startRequiredOut(startRequiredOut),
      .cycleTimeExceededOut(cycleTimeExceededOut), .mutingOut(mutingOut));
   pci_press_model #(.TICK(TICK)) pci_press_model_i (.clk(clk), .curtain(curtain),
      .top(top), .startup(startup), .start(start));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
      numChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chkBit(input string what, input logic exp, input logic got);
      chkWord(what, {31'h0, exp}, {31'h0, got});
   endtask

   task automatic waitMs(input int ms);
      repeat (ms * TICK) @(posedge clk);
   endtask

   task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic regRead(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask

   task automatic test_done();
      $display("Checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_regs();
      regRead(`PCI_REG_CFG, rd);
      chkWord("config reset", {19'h0, `PCI_CFG_RST}, rd);
      regRead(`PCI_REG_CYCT, rd);
      chkWord("cycle limit reset", {23'h0, `PCI_CYCT_DEF_S}, rd);
      regRead(`PCI_REG_MUTE, rd);
      chkWord("muting reset", {19'h0, `PCI_MUTE_RST}, rd);
      regRead(4'h2, rd);
      chkWord("unmapped read", 32'h0, rd);
      regWrite(`PCI_REG_MUTE, 32'h0000_2328);
      regRead(`PCI_REG_MUTE, rd);
      chkWord("muting clamp", {19'h0, `PCI_MUTE_MAX_S}, rd);
      regWrite(`PCI_REG_CYCT, 32'h0000_0258);
      regRead(`PCI_REG_CYCT, rd);
      chkWord("cycle limit clamp", {23'h0, `PCI_CYCT_MAX_S}, rd);
      regWrite(`PCI_REG_MUTE, 32'h0);
      regWrite(`PCI_REG_CYCT, 32'h0);
      chkBit("release after reset", 1'b0, releaseOut);
      chkBit("cycle request after reset", 1'b1, cycleRequiredOut);
      $display("test_regs finished");
   endtask

   task automatic test_start();
      pci_press_model_i.pulse(CURT, 1'b0, 150);
      waitMs(2);
      chkBit("early intervention ignored", 1'b1, cycleRequiredOut);
      pci_press_model_i.drive(TOP, 1'b1);
      pci_press_model_i.pulse(CURT, 1'b0, 50);
      waitMs(2);
      chkBit("short intervention ignored", 1'b1, cycleRequiredOut);
      pci_press_model_i.pulse(CURT, 1'b0, 150);
      waitMs(2);
      chkBit("cycles done", 1'b0, cycleRequiredOut);
      chkBit("start requested", 1'b1, startRequiredOut);
      chkBit("release before start", 1'b0, releaseOut);
      pci_press_model_i.pulse(STRT, 1'b1, 150);
      waitMs(2);
      chkBit("release after start", 1'b1, releaseOut);
      chkBit("start request cleared", 1'b0, startRequiredOut);
      $display("test_start finished");
   endtask

   task automatic test_intrude();
      pci_press_model_i.drive(TOP, 1'b0);
      waitMs(2);
      chkBit("running", 1'b1, releaseOut);
      fork
         pci_press_model_i.pulse(CURT, 1'b0, 150);
         begin
            waitMs(20);
            chkBit("release on intrusion", 1'b0, releaseOut);
            chkBit("field on intrusion", 1'b1, fieldIntervOut);
         end
      join
      waitMs(2);
      chkBit("interlock latched", 1'b0, releaseOut);
      $display("test_intrude finished");
   endtask

   task automatic test_overrun();
      regWrite(`PCI_REG_CYCT, 32'h1);
      pci_press_model_i.drive(TOP, 1'b1);
      waitMs(900);
      chkBit("no overrun yet", 1'b0, cycleTimeExceededOut);
      waitMs(200);
      chkBit("overrun flagged", 1'b1, cycleTimeExceededOut);
      regWrite(`PCI_REG_CYCT, 32'h0);
      regWrite(`PCI_REG_CFG, 32'h0000_04C1);
      release2In <= 1'b0;
      pci_press_model_i.pulse(CURT, 1'b0, 150);
      pci_press_model_i.pulse(STRT, 1'b1, 150);
      waitMs(2);
      chkBit("release without release 2", 1'b0, releaseOut);
      release2In <= 1'b1;
      waitMs(2);
      chkBit("release after full sequence", 1'b1, releaseOut);
      $display("test_overrun finished");
   endtask

   task automatic test_muting();
      pci_press_model_i.drive(TOP, 1'b0);
      regWrite(`PCI_REG_CFG, 32'h0000_0501);
      regWrite(`PCI_REG_MUTE, 32'h1);
      pci_press_model_i.drive(STUP, 1'b1);
      waitMs(3);
      chkBit("muting on", 1'b1, mutingOut);
      pci_press_model_i.drive(CURT, 1'b0);
      waitMs(20);
      chkBit("release while muted", 1'b1, releaseOut);
      pci_press_model_i.drive(STUP, 1'b0);
      waitMs(3);
      chkBit("muting off", 1'b0, mutingOut);
      chkBit("release after muting", 1'b0, releaseOut);
      chkBit("field after muting", 1'b1, fieldIntervOut);
      pci_press_model_i.drive(CURT, 1'b1);
      @(posedge clk);
      release1In <= 1'b0;
      waitMs(1);
      chkBit("main release low", 1'b0, releaseOut);
      $display("test_muting finished");
   endtask

   // ---------------------------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      test_regs();
      test_start();
      test_intrude();
      test_overrun();
      test_muting();
      test_done();
   end

   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      $display("[ERR] run length expected done seen hang");
      test_done();
   end
endmodule
`default_nettype wire
